// ### atm_pkg.sv
package atm_pkg;
   // Status picker encodings
   localparam logic PICK_ACQ = 1'b0;
   localparam logic PICK_FRAME = 1'b1;
   // Output line source encodings
   localparam logic [1:0] SRC_PERMIT = 2'h0;
   localparam logic [1:0] SRC_EXPOSURE = 2'h1;
   localparam logic [1:0] SRC_ACQ_WAIT = 2'h2;
   localparam logic [1:0] SRC_FRAME_WAIT = 2'h3;
   // Frame budget counter width and reset values
   localparam int FRAME_CNT_W = 8;
   localparam logic [FRAME_CNT_W-1:0] FRAMES_RESET = 8'h01;
   localparam logic [FRAME_CNT_W-1:0] CNT_ZERO = 8'h00;
   // Acquisition sequencer states, Gray coded along the usual path
   typedef enum logic [1:0] {
      ATM_IDLE = 2'b00,
      ATM_ACQ_WAIT = 2'b01,
      ATM_FRAME_WAIT = 2'b11,
      ATM_CAPTURE = 2'b10
   } atm_state_t;
endpackage

// ### atm_sync2.sv
`timescale 1ns/100ps
// Two-flop synchroniser for pin inputs
module atm_sync2 (
   input wire logic clk_in, // Clock
   input wire logic reset_in, // Synchronous reset
   input wire logic async_in, // Pin level
   output logic sync_out // Level in clock domain
);
   logic meta; // First stage, read only by the second
   // Both stages clear on reset
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// ### atm_monitor.sv
`timescale 1ns/100ps
// Contract
// - Permit window output follows window open/close
// - Global shutter: permit window equals exposure
// - Line mux selects permit window; direction gate
// - Software acq trigger outside wait: overtrigger
// - Software frame trigger outside wait: overtrigger
// - Hardware acq trigger outside wait: overtrigger
// - Hardware frame trigger outside wait: overtrigger
// - Picker selects wait state for status value
// - Acq wait output rises on entering wait
// - Acq wait output falls on accepted trigger
// - Acq wait output only with hardware triggering
// - Frame wait output shows frame wait state
// - Frame wait rises on entry, falls on trigger
// - Frame wait output only with hardware triggering
module atm_monitor (
   input wire logic clk_in, // 250 MHz clock
   input wire logic reset_in, // Synchronous reset, active high
   input wire logic acquisition_enable_in, // Acquisition running level
   input wire logic ext_acq_begin_trigger_in, // Hardware acq trigger pin
   input wire logic hw_frame_begin_trigger_in, // Hardware frame trigger pin
   input wire logic sw_acq_trigger_in, // Software acq trigger pulse
   input wire logic sw_frame_trigger_in, // Software frame trigger pulse
   input wire logic hw_acq_mode_in, // 1: hardware acq triggering
   input wire logic hw_frame_mode_in, // 1: hardware frame triggering
   input wire logic frame_trigger_on_in, // 0: frames generated internally
   input wire logic [atm_pkg::FRAME_CNT_W-1:0] frames_per_burst_in, // Frames per acquisition
   input wire logic capture_done_in, // Frame capture finished pulse
   input wire logic exposure_in_progress_in, // Exposure from sensor timing
   input wire logic sensor_window_in, // Rolling shutter permit window
   input wire logic global_shutter_in, // 1: global shutter mode
   input wire logic wait_status_picker_in, // Status selector
   input wire logic [1:0] line_signal_origin_in, // Line source select
   input wire logic line_direction_in, // 1: bidirectional line is output
   input wire logic acq_over_ack_in, // Clear acq overtrigger flag
   input wire logic frame_over_ack_in, // Clear frame overtrigger flag
   output logic lighting_permit_window_out, // Permit window
   output logic acq_begin_waiting_out, // Acq wait signal
   output logic frame_begin_waiting_out, // Frame wait signal
   output logic wait_status_value_out, // Selected wait status
   output logic bidirectional_line_b_out, // Line driven level
   output logic bidirectional_line_b_oe_n_out, // Low while line driven
   output logic acq_overtrigger_out, // Sticky acq overtrigger flag
   output logic frame_overtrigger_out // Sticky frame overtrigger flag
);
   import atm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   logic acq_pin_s; // Synchronised acq pin
   logic frame_pin_s; // Synchronised frame pin
   logic acq_pin_d; // Previous acq pin level
   logic frame_pin_d; // Previous frame pin level
   logic hw_acq_edge; // Rising edge of acq pin
   logic hw_frame_edge; // Rising edge of frame pin

   atm_sync2 u_sync_acq (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .async_in(ext_acq_begin_trigger_in),
      .sync_out(acq_pin_s)
   );

   atm_sync2 u_sync_frame (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .async_in(hw_frame_begin_trigger_in),
      .sync_out(frame_pin_s)
   );

   // Delay of synchronised levels for edges
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         acq_pin_d <= 1'b0;
         frame_pin_d <= 1'b0;
      end else begin
         acq_pin_d <= acq_pin_s;
         frame_pin_d <= frame_pin_s;
      end
   end

   assign hw_acq_edge = acq_pin_s & ~acq_pin_d;
   assign hw_frame_edge = frame_pin_s & ~frame_pin_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Trigger qualification by mode
   logic acq_trig; // Acq trigger from the active source
   logic frame_trig; // Frame trigger from the active source
   logic in_acq_wait; // Waiting for acq trigger
   logic in_frame_wait; // Waiting for frame trigger
   atm_state_t state; // Sequencer state
   atm_state_t next_state; // Next sequencer state
   logic [FRAME_CNT_W-1:0] frames_left; // Frames still due in burst
   logic [FRAME_CNT_W-1:0] next_frames_left; // Next frame count

   // Only the selected source reaches the sequencer
   assign acq_trig = hw_acq_mode_in ? hw_acq_edge : sw_acq_trigger_in;
   assign frame_trig = hw_frame_mode_in ? hw_frame_edge : sw_frame_trigger_in;
   assign in_acq_wait = (state == ATM_ACQ_WAIT);
   assign in_frame_wait = (state == ATM_FRAME_WAIT);

   ////////////////////////////////////////////////////////////////////////////////
   // Acquisition sequencer
   // Triggers outside their wait state leave the state untouched
   always_comb begin
      next_state = state;
      next_frames_left = frames_left;
      case (state)
         ATM_IDLE: begin
            if (acquisition_enable_in) begin
               next_state = ATM_ACQ_WAIT;
            end
         end
         ATM_ACQ_WAIT: begin
            if (!acquisition_enable_in) begin
               next_state = ATM_IDLE;
            end else if (acq_trig) begin
               next_state = ATM_FRAME_WAIT;
               next_frames_left = (frames_per_burst_in == CNT_ZERO) ? FRAMES_RESET : frames_per_burst_in;
            end
         end
         ATM_FRAME_WAIT: begin
            if (!acquisition_enable_in) begin
               next_state = ATM_IDLE;
            end else if (frame_trig || !frame_trigger_on_in) begin
               next_state = ATM_CAPTURE;
               next_frames_left = frames_left - 8'h01;
            end
         end
         ATM_CAPTURE: begin
            if (capture_done_in) begin
               // Re-enter acq wait once the burst is spent
               if (!acquisition_enable_in) begin
                  next_state = ATM_IDLE;
               end else if (frames_left == CNT_ZERO) begin
                  next_state = ATM_ACQ_WAIT;
               end else begin
                  next_state = ATM_FRAME_WAIT;
               end
            end
         end
         default: begin
            next_state = ATM_IDLE;
         end
      endcase
   end

   // State and frame counter
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= ATM_IDLE;
         frames_left <= FRAMES_RESET;
      end else begin
         state <= next_state;
         frames_left <= next_frames_left;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wait outputs and status
   // Wait pins are only meaningful in hardware trigger mode
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         acq_begin_waiting_out <= 1'b0;
         frame_begin_waiting_out <= 1'b0;
      end else begin
         acq_begin_waiting_out <= hw_acq_mode_in & (next_state == ATM_ACQ_WAIT);
         frame_begin_waiting_out <= hw_frame_mode_in & (next_state == ATM_FRAME_WAIT);
      end
   end

   // Software-readable status via picker
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wait_status_value_out <= 1'b0;
      end else if (wait_status_picker_in == PICK_FRAME) begin
         wait_status_value_out <= (next_state == ATM_FRAME_WAIT);
      end else begin
         wait_status_value_out <= (next_state == ATM_ACQ_WAIT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overtrigger flags; a new event wins over a same-cycle acknowledge
   logic acq_over_evt; // Acq trigger outside acq wait
   logic frame_over_evt; // Frame trigger outside frame wait

   assign acq_over_evt = acq_trig & ~in_acq_wait;
   assign frame_over_evt = frame_trig & ~in_frame_wait;

   // Acq overtrigger flag
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         acq_overtrigger_out <= 1'b0;
      end else if (acq_over_evt) begin
         acq_overtrigger_out <= 1'b1;
      end else if (acq_over_ack_in) begin
         acq_overtrigger_out <= 1'b0;
      end
   end

   // Frame overtrigger flag
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         frame_overtrigger_out <= 1'b0;
      end else if (frame_over_evt) begin
         frame_overtrigger_out <= 1'b1;
      end else if (frame_over_ack_in) begin
         frame_overtrigger_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Lighting permit window and output line
   logic permit; // Combined permit window level
   logic line_level; // Selected line source level

   // Global shutter copies exposure, rolling uses sensor window
   assign permit = global_shutter_in ? exposure_in_progress_in : sensor_window_in;

   // Line source multiplexer
   always_comb begin
      case (line_signal_origin_in)
         SRC_PERMIT: line_level = permit;
         SRC_EXPOSURE: line_level = exposure_in_progress_in;
         SRC_ACQ_WAIT: line_level = hw_acq_mode_in & in_acq_wait;
         SRC_FRAME_WAIT: line_level = hw_frame_mode_in & in_frame_wait;
         default: line_level = 1'b0;
      endcase
   end

   // Registered outputs; line only driven when set to output
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         lighting_permit_window_out <= 1'b0;
         bidirectional_line_b_out <= 1'b0;
         bidirectional_line_b_oe_n_out <= 1'b1;
      end else begin
         lighting_permit_window_out <= permit;
         bidirectional_line_b_out <= line_level;
         bidirectional_line_b_oe_n_out <= ~line_direction_in;
      end
   end
endmodule

// ### atm_monitor_props.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Port-level checks on the monitor
module atm_monitor_props
   import atm_pkg::*;
(
   input wire logic clk_in, // Clock
   input wire logic reset_in, // Reset
   input wire logic exposure_in_progress_in, // Exposure
   input wire logic sensor_window_in, // Window
   input wire logic global_shutter_in, // Shutter mode
   input wire logic line_direction_in, // Direction
   input wire logic hw_acq_mode_in, // Acq mode
   input wire logic hw_frame_mode_in, // Frame mode
   input wire logic wait_status_picker_in, // Picker
   input wire logic sw_acq_trigger_in, // Sw trigger
   input wire logic acq_over_ack_in, // Ack
   input wire logic ext_acq_begin_trigger_in, // Acq pin
   input wire logic hw_frame_begin_trigger_in, // Frame pin
   input wire logic lighting_permit_window_out, // Permit
   input wire logic acq_begin_waiting_out, // Acq wait
   input wire logic frame_begin_waiting_out, // Frame wait
   input wire logic wait_status_value_out, // Status
   input wire logic bidirectional_line_b_oe_n_out, // Enable
   input wire logic acq_overtrigger_out, // Acq flag
   input wire logic frame_overtrigger_out // Frame flag
);
   // Single domain, so clock and reset are given once
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // First edge after reset is skipped: $past still sees reset values
   property p_permit;
      !$past(reset_in) |-> lighting_permit_window_out ==
         $past(global_shutter_in ? exposure_in_progress_in : sensor_window_in);
   endproperty
   a_permit: assert property (p_permit) else $error("permit window mismatch");
   property p_oe;
      !$past(reset_in) |-> bidirectional_line_b_oe_n_out == !$past(line_direction_in);
   endproperty
   a_oe: assert property (p_oe) else $error("line enable mismatch");
   property p_acq_hide;
      !$past(reset_in) && !$past(hw_acq_mode_in) |-> !acq_begin_waiting_out;
   endproperty
   a_acq_hide: assert property (p_acq_hide) else $error("acq wait shown in sw mode");
   property p_frame_hide;
      !$past(reset_in) && !$past(hw_frame_mode_in) |-> !frame_begin_waiting_out;
   endproperty
   a_frame_hide: assert property (p_frame_hide) else $error("frame wait shown in sw mode");
   property p_status;
      !$past(reset_in) && $past(wait_status_picker_in) == PICK_ACQ && $past(hw_acq_mode_in)
         |-> wait_status_value_out == acq_begin_waiting_out;
   endproperty
   a_status: assert property (p_status) else $error("status differs from acq wait");
   property p_sticky;
      !$past(reset_in) && $past(acq_overtrigger_out) && !$past(acq_over_ack_in) |-> acq_overtrigger_out;
   endproperty
   a_sticky: assert property (p_sticky) else $error("acq flag dropped without ack");
   property p_sw_over;
      !hw_acq_mode_in && sw_acq_trigger_in && $past(wait_status_picker_in) == PICK_ACQ
         && !wait_status_value_out |=> acq_overtrigger_out;
   endproperty
   a_sw_over: assert property (p_sw_over) else $error("sw acq overtrigger missed");
   property p_acq_fall;
      $rose(ext_acq_begin_trigger_in) && hw_acq_mode_in && acq_begin_waiting_out
         |-> ##[1:6] !acq_begin_waiting_out;
   endproperty
   a_acq_fall: assert property (p_acq_fall) else $error("acq wait did not fall");
   // Entering frame wait inside the window also excuses the flag
   property p_frame_over;
      $rose(hw_frame_begin_trigger_in) && hw_frame_mode_in && !frame_begin_waiting_out
         |-> ##[1:6] (frame_overtrigger_out || frame_begin_waiting_out);
   endproperty
   a_frame_over: assert property (p_frame_over) else $error("hw frame overtrigger missed");
   c_acq_over: cover property (acq_overtrigger_out);
   c_acq_wait: cover property (acq_begin_waiting_out);
   c_frame_wait: cover property (frame_begin_waiting_out);
endmodule

// ### atm_trig_src.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// External trigger source driving one pin
module atm_trig_src (
   input wire logic clk_in, // Clock
   input wire logic wait_in, // Matching wait line
   output logic pin_out // Trigger pin
);
   initial pin_out = 1'b0;
   // Honest calls wait for the wait line; bounded so a dead line cannot hang
   task automatic fire(input bit honest);
      int n;
      n = 0;
      while (honest && !wait_in && n < 50) begin
         @(negedge clk_in);
         n++;
      end
      pin_out = 1'b1;
      repeat (4) @(negedge clk_in);
      pin_out = 1'b0;
      repeat (6) @(negedge clk_in);
   endtask
endmodule

// ### acquisition_trigger_monitor_bench.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Inputs change on falling edges
module acquisition_trigger_monitor_bench;
   import atm_pkg::*;
   logic clk_in, reset_in, acquisition_enable_in, sw_acq_trigger_in, sw_frame_trigger_in;
   logic hw_acq_mode_in, hw_frame_mode_in, frame_trigger_on_in, capture_done_in, global_shutter_in;
   logic exposure_in_progress_in, sensor_window_in, wait_status_picker_in, line_direction_in;
   logic acq_over_ack_in, frame_over_ack_in, ext_acq_begin_trigger_in, hw_frame_begin_trigger_in;
   logic [FRAME_CNT_W-1:0] frames_per_burst_in;
   logic [1:0] line_signal_origin_in;
   logic lighting_permit_window_out, acq_begin_waiting_out, frame_begin_waiting_out, wait_status_value_out;
   logic bidirectional_line_b_out, bidirectional_line_b_oe_n_out, acq_overtrigger_out, frame_overtrigger_out;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   atm_monitor dut (.*);
   atm_trig_src acq_src (.clk_in(clk_in), .wait_in(acq_begin_waiting_out), .pin_out(ext_acq_begin_trigger_in));
   atm_trig_src frm_src (.clk_in(clk_in), .wait_in(frame_begin_waiting_out), .pin_out(hw_frame_begin_trigger_in));
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic chk(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask
   // One-cycle pulse, then time for the registered answer
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(3);
   endtask
   task automatic t_lines();
      for (int i = 0; i < 8; i++) begin
         {global_shutter_in, exposure_in_progress_in, sensor_window_in} = i[2:0];
         tick(3);
         chk("permit", i[2] ? i[1] : i[0], lighting_permit_window_out);
         chk("line", i[2] ? i[1] : i[0], bidirectional_line_b_out);
      end
      line_direction_in = 1'b0;
      tick(3);
      chk("line_oe_n", 1'b1, bidirectional_line_b_oe_n_out);
      line_direction_in = 1'b1;
      tick(3);
      chk("line_oe_n", 1'b0, bidirectional_line_b_oe_n_out);
      $display("test lines done");
   endtask
   task automatic t_sw();
      acquisition_enable_in = 1'b1;
      tick(3);
      chk("acq_status", 1'b1, wait_status_value_out);
      chk("acq_wait_sw", 1'b0, acq_begin_waiting_out);
      pulse(sw_frame_trigger_in);
      chk("frame_over", 1'b1, frame_overtrigger_out);
      pulse(frame_over_ack_in);
      chk("frame_over_ack", 1'b0, frame_overtrigger_out);
      pulse(sw_acq_trigger_in);
      chk("acq_status", 1'b0, wait_status_value_out);
      chk("acq_over", 1'b0, acq_overtrigger_out);
      wait_status_picker_in = PICK_FRAME;
      tick(2);
      chk("frame_status", 1'b1, wait_status_value_out);
      chk("frame_wait_sw", 1'b0, frame_begin_waiting_out);
      // Back to the acq picker so the refused trigger is seen against a false status
      wait_status_picker_in = PICK_ACQ;
      tick(2);
      chk("acq_status", 1'b0, wait_status_value_out);
      pulse(sw_acq_trigger_in);
      chk("acq_over", 1'b1, acq_overtrigger_out);
      $display("test software done");
   endtask
   task automatic t_hw();
      pulse(acq_over_ack_in);
      hw_acq_mode_in = 1'b1;
      hw_frame_mode_in = 1'b1;
      tick(2);
      chk("acq_over_ack", 1'b0, acq_overtrigger_out);
      chk("frame_wait", 1'b1, frame_begin_waiting_out);
      frm_src.fire(1'b1);
      chk("frame_wait", 1'b0, frame_begin_waiting_out);
      pulse(capture_done_in);
      chk("acq_wait", 1'b1, acq_begin_waiting_out);
      chk("acq_status", 1'b1, wait_status_value_out);
      frm_src.fire(1'b0);
      chk("frame_over", 1'b1, frame_overtrigger_out);
      acq_src.fire(1'b1);
      chk("acq_wait", 1'b0, acq_begin_waiting_out);
      chk("frame_wait", 1'b1, frame_begin_waiting_out);
      acq_src.fire(1'b0);
      chk("acq_over", 1'b1, acq_overtrigger_out);
      $display("test hardware done");
   endtask
   // Internal frames, line sources, a three-frame burst and re-entry after disable
   task automatic t_burst();
      pulse(acq_over_ack_in);
      frame_trigger_on_in = 1'b0;
      frames_per_burst_in = 8'h03;
      tick(2);
      chk("frame_wait_int", 1'b0, frame_begin_waiting_out);
      pulse(capture_done_in);
      chk("acq_wait", 1'b1, acq_begin_waiting_out);
      line_signal_origin_in = SRC_ACQ_WAIT;
      tick(2);
      chk("line_acq_wait", 1'b1, bidirectional_line_b_out);
      line_signal_origin_in = SRC_FRAME_WAIT;
      tick(2);
      chk("line_frame_wait", 1'b0, bidirectional_line_b_out);
      line_signal_origin_in = SRC_EXPOSURE;
      tick(2);
      chk("line_exposure", 1'b1, bidirectional_line_b_out);
      line_signal_origin_in = SRC_PERMIT;
      acq_src.fire(1'b1);
      // Wait stays low until the third capture of the burst is done
      for (int k = 0; k < 3; k++) begin
         chk("acq_wait_burst", 1'b0, acq_begin_waiting_out);
         pulse(capture_done_in);
      end
      chk("acq_wait_burst", 1'b1, acq_begin_waiting_out);
      acquisition_enable_in = 1'b0;
      tick(2);
      chk("acq_wait_off", 1'b0, acq_begin_waiting_out);
      acquisition_enable_in = 1'b1;
      tick(2);
      chk("acq_wait_again", 1'b1, acq_begin_waiting_out);
      $display("test burst done");
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Whole run needs under two hundred cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         results();
      end
   end
   initial begin
      {acquisition_enable_in, sw_acq_trigger_in, sw_frame_trigger_in, hw_acq_mode_in} = 4'h0;
      {hw_frame_mode_in, capture_done_in, exposure_in_progress_in, sensor_window_in} = 4'h0;
      {global_shutter_in, acq_over_ack_in, frame_over_ack_in, wait_status_picker_in} = 4'h0;
      frame_trigger_on_in = 1'b1;
      line_direction_in = 1'b1;
      line_signal_origin_in = SRC_PERMIT;
      frames_per_burst_in = 8'h01;
      reset_in = 1'b1;
      tick(8);
      reset_in = 1'b0;
      tick(2);
      t_lines();
      t_sw();
      t_hw();
      t_burst();
      results();
   end
endmodule
bind atm_monitor atm_monitor_props props (.*);
